// ### core/gpc_pkg.sv
// shared constants and types of the global parameter command handler
// assumes command frames arrive byte-serially, most significant value byte first
package gpc_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_SET_GP = 8'h09;
  localparam logic [7:0] OP_GET_GP = 8'h0A;
  localparam logic [7:0] OP_STORE_GP = 8'h0B;
  localparam logic [7:0] OP_RESTORE_GP = 8'h0C;
  localparam logic [7:0] OP_SET_OUT = 8'h0E;

  // ---------------------------------------------------------------
  // banks, parameter numbers, ports
  // ---------------------------------------------------------------
  localparam logic [7:0] BANK_GLOBAL = 8'h00;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] BANK_IRQ = 8'h03;
  localparam logic [7:0] PAR_SERIAL_ADDR = 8'h42;
  localparam logic [7:0] OUT_PORT = 8'h00;
  localparam logic [9:0] SERIAL_IDX = {2'b00, PAR_SERIAL_ADDR};

  // ---------------------------------------------------------------
  // reply status codes (error codes are arbitrary values)
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h64;
  localparam logic [7:0] ST_BAD_CKSUM = 8'h01;
  localparam logic [7:0] ST_BAD_CMD = 8'h02;
  localparam logic [7:0] ST_BAD_VALUE = 8'h04;

  // ---------------------------------------------------------------
  // reset values, frame layout, restore walk
  // ---------------------------------------------------------------
  localparam logic [7:0] SERIAL_ADDR_RST = 8'h01;
  localparam logic [7:0] HOST_ADDR = 8'h02;
  localparam logic [3:0] FRAME_LEN = 4'h9;
  localparam int P_ADDR = 64;
  localparam int P_OP = 56;
  localparam int P_TYPE = 48;
  localparam int P_BANK = 40;
  localparam int P_VAL = 8;
  localparam logic [8:0] INIT_LAST = 9'h1FF;

  typedef enum logic [1:0] {S_INIT, S_IDLE, S_NV, S_REPLY} gpc_state_t;

  // modulo-256 sum of eight bytes
  function automatic logic [7:0] gpc_sum8(input logic [63:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = 8'(s + b[8*i +: 8]);
    end
    return s;
  endfunction

endpackage

// ### core/gpc_frame_rx.sv
// collects one nine-byte command frame and checks its checksum
// assumes the consumer takes the frame with frm_take while frm_valid
module gpc_frame_rx
  import gpc_pkg::*;
(
  input logic CLK,
  input logic RESET,
  input logic [7:0] rx_data,
  input logic rx_valid,
  output logic rx_ready,
  output logic frm_valid,
  output logic [71:0] frm,
  output logic frm_ck_ok,
  input logic frm_take
);

  logic [3:0] cnt;

  // ---------------------------------------------------------------
  // handshake and checksum
  // ---------------------------------------------------------------
  assign frm_valid = (cnt == FRAME_LEN);
  assign rx_ready = !frm_valid;
  assign frm_ck_ok = (gpc_sum8(frm[71:8]) == frm[7:0]); // R12

  // shift bytes in, first byte ends on top
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt <= 4'h0;
      frm <= 72'h0;
    end else if (frm_valid) begin
      if (frm_take) begin
        cnt <= 4'h0;
      end
    end else if (rx_valid) begin
      frm <= {frm[63:0], rx_data}; // R12
      cnt <= 4'(cnt + 4'h1);
    end
  end

endmodule

// ### core/gpc_reply_tx.sv
// sends one nine-byte reply frame with its checksum appended
// assumes start is raised only while busy is low
module gpc_reply_tx
  import gpc_pkg::*;
(
  input logic CLK,
  input logic RESET,
  input logic start,
  input logic [63:0] bytes_in,
  output logic busy,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input logic tx_ready
);

  logic [71:0] sh;
  logic [3:0] cnt;

  // ---------------------------------------------------------------
  // output side
  // ---------------------------------------------------------------
  assign busy = (cnt != 4'h0);
  assign tx_valid = busy;
  assign tx_data = sh[71:64];

  // load, then shift one byte per accepted beat
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sh <= 72'h0;
      cnt <= 4'h0;
    end else if (!busy) begin
      if (start) begin
        sh <= {bytes_in, gpc_sum8(bytes_in)}; // R12
        cnt <= FRAME_LEN;
      end
    end else if (tx_ready) begin
      sh <= {sh[63:0], 8'h00};
      cnt <= 4'(cnt - 4'h1);
    end
  end

endmodule

// ### core/gpc_cmd_core.sv
// command handler for global parameters, user variables and the output
// assumes a byte link to the host and a request/ack non-volatile store

// Behaviour
// (R1) get-global copies selected parameter to accumulator
// (R2) banks 0 global, 2 user, 3 interrupt
// (R3) get-global replies OK with read value
// (R4) store-global bank 2 writes variable to store
// (R5) bank 0 writes go to store automatically
// (R6) restore-global bank 2 reloads variable from store
// (R7) user variables reloaded from store after reset
// (R8) set-output drives chosen line, replies OK
// (R9) single output at port 0 bank 2
// (R10) serial address is bank 0 parameter 66
// (R11) set-global copies value into selected parameter
// (R12) nine-byte frame, big-endian value, sum checksum
module gpc_cmd_core
  import gpc_pkg::*;
#(
  parameter bit AUTO_RESTORE = 1'b1
)
(
  input logic CLK,
  input logic RESET,
  input logic [7:0] RX_DATA,
  input logic RX_VALID,
  output logic RX_READY,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input logic TX_READY,
  output logic NV_REQ,
  output logic NV_WE,
  output logic [9:0] NV_ADDR,
  output logic [31:0] NV_WDATA,
  input logic [31:0] NV_RDATA,
  input logic NV_ACK,
  output logic GP_OUT,
  output logic [31:0] ACCUM,
  output logic [7:0] SERIAL_ADDR
);

  gpc_state_t state;
  logic [71:0] frm;
  logic frm_valid;
  logic frm_ck_ok;
  logic frm_take;
  logic tx_busy;
  logic tx_start;
  logic [31:0] par [0:1023];
  logic [8:0] init_idx;
  logic [7:0] serial_addr;
  logic [7:0] rsp_status;
  logic [7:0] rsp_op;
  logic [31:0] rsp_value;
  logic gp_out;
  logic [31:0] accum;
  logic nv_req;
  logic nv_we;
  logic [9:0] nv_addr;
  logic [31:0] nv_wdata;

  // ---------------------------------------------------------------
  // frame receive and reply send
  // ---------------------------------------------------------------
  gpc_frame_rx u_rx (
    .CLK(CLK),
    .RESET(RESET),
    .rx_data(RX_DATA),
    .rx_valid(RX_VALID),
    .rx_ready(RX_READY),
    .frm_valid(frm_valid),
    .frm(frm),
    .frm_ck_ok(frm_ck_ok),
    .frm_take(frm_take)
  );

  gpc_reply_tx u_tx (
    .CLK(CLK),
    .RESET(RESET),
    .start(tx_start),
    .bytes_in({HOST_ADDR, serial_addr, rsp_status, rsp_op, rsp_value}),
    .busy(tx_busy),
    .tx_data(TX_DATA),
    .tx_valid(TX_VALID),
    .tx_ready(TX_READY)
  );

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire [7:0] f_addr = frm[P_ADDR +: 8];
  wire [7:0] f_op = frm[P_OP +: 8];
  wire [7:0] f_type = frm[P_TYPE +: 8];
  wire [7:0] f_bank = frm[P_BANK +: 8];
  wire [31:0] f_val = frm[P_VAL +: 32];
  // bank code and parameter number form the table index
  wire [9:0] idx = {f_bank[1:0], f_type}; // R2
  wire bank_ok = (f_bank == BANK_GLOBAL) || (f_bank == BANK_USER) ||
    (f_bank == BANK_IRQ); // R2
  wire bank_user = (f_bank == BANK_USER);

  // command classes
  wire is_get = (f_op == OP_GET_GP) && bank_ok; // R1
  wire is_set = (f_op == OP_SET_GP) && bank_ok; // R11
  wire is_store = (f_op == OP_STORE_GP) && bank_user; // R4
  wire is_rest = (f_op == OP_RESTORE_GP) && bank_user; // R6
  wire is_out = (f_op == OP_SET_OUT) && bank_user && (f_type == OUT_PORT) &&
    (f_val[31:1] == 31'h0); // R9
  wire known_op = (f_op == OP_GET_GP) || (f_op == OP_SET_GP) ||
    (f_op == OP_STORE_GP) || (f_op == OP_RESTORE_GP) || (f_op == OP_SET_OUT);
  wire any_ok = is_get || is_set || is_store || is_rest || is_out;

  // reply status, checksum checked first
  wire [7:0] dec_status = !frm_ck_ok ? ST_BAD_CKSUM :
    !known_op ? ST_BAD_CMD :
    any_ok ? ST_OK : ST_BAD_VALUE; // R12
  wire ok = (dec_status == ST_OK);

  // frames for another address are dropped without reply
  wire for_us = (f_addr == serial_addr);
  wire accept = (state == S_IDLE) && frm_valid && for_us;
  wire get_ok = accept && ok && is_get;
  wire set_ok = accept && ok && is_set;
  wire out_ok = accept && ok && is_out;
  wire nv_go = accept && ok &&
    (is_store || is_rest || (is_set && (f_bank == BANK_GLOBAL))); // R5

  // parameter read, address lives in its own register
  wire [31:0] rd_val = (idx == SERIAL_IDX) ? {24'h0, serial_addr} : par[idx]; // R10

  // ---------------------------------------------------------------
  // table write port and handshakes
  // ---------------------------------------------------------------
  // a read acknowledge writes the table, as does a set
  wire nv_rd_done = nv_req && NV_ACK && !nv_we;
  wire wr_en = set_ok || nv_rd_done; // R11
  wire [9:0] wr_idx = accept ? idx : nv_addr;
  wire [31:0] wr_data = accept ? f_val : NV_RDATA; // R6
  wire [8:0] next_init = 9'(init_idx + 9'h001);
  assign frm_take = (state == S_IDLE) && frm_valid;
  assign tx_start = (state == S_REPLY) && !tx_busy;

  // outputs straight from flops
  assign NV_REQ = nv_req;
  assign NV_WE = nv_we;
  assign NV_ADDR = nv_addr;
  assign NV_WDATA = nv_wdata;
  assign GP_OUT = gp_out;
  assign ACCUM = accum;
  assign SERIAL_ADDR = serial_addr;

  // parameter table storage
  always_ff @(posedge CLK) begin
    if (wr_en) begin
      par[wr_idx] <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= AUTO_RESTORE ? S_INIT : S_IDLE; // R7
      nv_req <= AUTO_RESTORE;
      nv_we <= 1'b0;
      nv_addr <= 10'h000;
      nv_wdata <= 32'h0;
      init_idx <= 9'h000;
      rsp_status <= 8'h00;
      rsp_op <= 8'h00;
      rsp_value <= 32'h0;
      gp_out <= 1'b0;
      accum <= 32'h0;
      serial_addr <= SERIAL_ADDR_RST;
    end else begin
      if (wr_en && (wr_idx == SERIAL_IDX)) begin
        serial_addr <= wr_data[7:0]; // R10
      end
      unique case (state)
        S_INIT: begin
          // walk bank 0 then bank 2 out of the store
          if (NV_ACK) begin
            init_idx <= next_init; // R7
            nv_addr <= {next_init[8], 1'b0, next_init[7:0]}; // R7
            if (init_idx == INIT_LAST) begin
              nv_req <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        S_IDLE: begin
          // latch the reply and start any store access
          if (accept) begin
            rsp_status <= dec_status; // R3
            rsp_op <= f_op;
            rsp_value <= get_ok ? rd_val : 32'h0; // R3
            if (get_ok) begin
              accum <= rd_val; // R1
            end
            if (out_ok) begin
              gp_out <= f_val[0]; // R8
            end
            if (nv_go) begin
              nv_req <= 1'b1;
              nv_we <= !is_rest; // R4
              nv_addr <= idx;
              nv_wdata <= is_set ? f_val : par[idx]; // R5
              state <= S_NV;
            end else begin
              state <= S_REPLY;
            end
          end
        end
        S_NV: begin
          // request held until the store acknowledges
          if (NV_ACK) begin
            nv_req <= 1'b0;
            state <= S_REPLY;
          end
        end
        S_REPLY: begin
          // hand the reply over once the sender is free
          if (!tx_busy) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // one property per rule, plus store handshake and error checks

  AST_GET_ACCUM: assert property ( // R1
    get_ok |=> (accum == $past(rd_val)) && (state == S_REPLY))
    else $error("get did not load accumulator");
  AST_BANK_IDX: assert property ( // R2
    set_ok && (f_bank == BANK_IRQ) |=> (par[{2'b11, $past(f_type)}] == $past(f_val)))
    else $error("bank 3 write lands in wrong table");
  AST_GET_REPLY: assert property ( // R3
    get_ok |=> (rsp_status == ST_OK) && (rsp_value == $past(rd_val)))
    else $error("get reply wrong");
  AST_STORE_NV: assert property ( // R4
    accept && ok && is_store |=> NV_REQ && NV_WE && (NV_ADDR == $past(idx))
      && (NV_WDATA == $past(par[idx])))
    else $error("store did not write the store");
  AST_AUTO_STORE: assert property ( // R5
    set_ok && (f_bank == BANK_GLOBAL) |=> NV_REQ && NV_WE &&
      (NV_WDATA == $past(f_val)))
    else $error("bank 0 write not stored");
  AST_RESTORE: assert property ( // R6
    (state == S_NV) && NV_ACK && !nv_we |-> wr_en && (wr_data == NV_RDATA)
      ##1 (state == S_REPLY) && !NV_REQ)
    else $error("restore did not reload");
  AST_INIT_DONE: assert property ( // R7
    (state == S_INIT) && NV_ACK && (init_idx == INIT_LAST) |=>
      (state == S_IDLE) && !NV_REQ)
    else $error("restore walk did not finish");
  AST_SET_OUT: assert property ( // R8
    out_ok |=> (GP_OUT == $past(f_val[0])) && (rsp_status == ST_OK))
    else $error("output not driven");
  AST_ONE_OUT: assert property ( // R9
    accept && frm_ck_ok && (f_op == OP_SET_OUT) && (f_type != OUT_PORT) |=>
      $stable(GP_OUT) && (rsp_status == ST_BAD_VALUE))
    else $error("unknown output port accepted");
  AST_SERIAL: assert property ( // R10
    set_ok && (idx == SERIAL_IDX) |=> (SERIAL_ADDR == $past(f_val[7:0])))
    else $error("serial address not updated");
  AST_SET_GP: assert property ( // R11
    set_ok |=> (par[$past(idx)] == $past(f_val)))
    else $error("set did not write table");
  AST_CKSUM: assert property ( // R12
    accept && !frm_ck_ok |=> (rsp_status == ST_BAD_CKSUM) ##1 TX_VALID)
    else $error("bad checksum not reported");
  AST_USER_NO_STORE: assert property ( // R5
    set_ok && (f_bank != BANK_GLOBAL) |=> !NV_REQ && (state == S_REPLY))
    else $error("non-global set reached the store");
  AST_RESTORE_REQ: assert property ( // R6
    accept && ok && is_rest |=> NV_REQ && !NV_WE && (NV_ADDR == $past(idx)))
    else $error("restore did not request a read");
  AST_ERR_QUIET: assert property ( // R3
    accept && !ok |=> $stable(ACCUM) && $stable(GP_OUT) && $stable(SERIAL_ADDR) &&
      (rsp_value == 32'h0))
    else $error("error reply changed state");
  AST_DROP: assert property ( // R10
    (state == S_IDLE) && frm_valid && !for_us |=> (state == S_IDLE))
    else $error("frame for another address was handled");
  AST_NV_HOLD: assert property ( // R4
    (state == S_NV) && NV_REQ && !NV_ACK |=> NV_REQ && $stable(NV_ADDR) && $stable(NV_WE) &&
      $stable(NV_WDATA))
    else $error("store request dropped before ack");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  CVR_GET: cover property (get_ok ##[1:20] TX_VALID);
  CVR_STORE: cover property (accept && is_store ##[1:20] (state == S_REPLY));
  CVR_RESTORE: cover property (nv_rd_done && (state == S_NV));
  CVR_OUT: cover property (out_ok && f_val[0]);
  CVR_BAD_CKSUM: cover property (accept && !frm_ck_ok);

endmodule

// ### verification/gpc_host_model.sv
// host side model: sends command frames byte by byte and collects replies
// assumes the device takes a byte where valid and ready meet at a rising edge
module gpc_host_model (
  input wire logic CLK,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  bit slow = 1'b0;
  initial begin
    RX_DATA = 8'h00;
    RX_VALID = 1'b0;
    TX_READY = 1'b0;
  end
  // ---------------------------------------------------------------
  // one frame, first byte is the target address, sum byte last
  // ---------------------------------------------------------------
  task automatic send(input logic [71:0] frm, output bit ok);
    int n;
    bit r;
    ok = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      RX_DATA = frm[8*i +: 8];
      RX_VALID = 1'b1;
      n = 0;
      r = 1'b0;
      while (!r && n < 2000) begin
        @(negedge CLK);
        r = RX_READY;
        @(posedge CLK);
        n++;
      end
      if (!r) ok = 1'b0;
      #1;
    end
    RX_VALID = 1'b0;
    RX_DATA = ~RX_DATA; // released line shows no stale byte
  endtask
  // ---------------------------------------------------------------
  // nine reply bytes, optionally stalling before each one
  // ---------------------------------------------------------------
  task automatic recv(output logic [71:0] rsp, output bit ok);
    int n;
    bit got;
    ok = 1'b1;
    rsp = '0;
    for (int i = 8; i >= 0; i--) begin
      if (slow) begin
        TX_READY = 1'b0;
        repeat (3) @(posedge CLK);
        #1;
      end
      TX_READY = 1'b1;
      got = 1'b0;
      n = 0;
      while (!got && n < 2000) begin
        @(negedge CLK);
        got = TX_VALID;
        rsp[8*i +: 8] = TX_DATA;
        @(posedge CLK);
        n++;
      end
      #1;
      if (!got) ok = 1'b0;
    end
    TX_READY = 1'b0;
  endtask
endmodule

// ### verification/global_param_and_output_cmds_tb.sv
// self-checking bench of the command handler with a host model and a store
// assumes the store acks every other cycle and the power-up walk is enabled
module global_param_and_output_cmds_tb import gpc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, rx_valid, rx_ready, tx_valid, tx_ready, nv_req, nv_we, gp_out;
  logic nv_ack = 1'b0;
  logic [7:0] rx_data, tx_data, serial_addr;
  logic [9:0] nv_addr;
  logic [31:0] nv_wdata, nv_rdata, accum;
  logic [31:0] nv_mem [0:1023];
  logic [7:0] dev = 8'h01;
  logic [7:0] dev_next = 8'h01;
  int fails = 0;
  int n_checks = 0;

  gpc_cmd_core #(.AUTO_RESTORE(1'b1)) dut_u (.CLK(clk), .RESET(reset), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .NV_REQ(nv_req), .NV_WE(nv_we), .NV_ADDR(nv_addr),
    .NV_WDATA(nv_wdata), .NV_RDATA(nv_rdata), .NV_ACK(nv_ack), .GP_OUT(gp_out),
    .ACCUM(accum), .SERIAL_ADDR(serial_addr));
  gpc_host_model host_u (.CLK(clk), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready));

  // ---------------------------------------------------------------
  // clock and store model
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    for (int i = 0; i < 1024; i++) nv_mem[i] = 32'h1000 + i;
    nv_mem[10'h042] = 32'h1; // stored module address
  end
  // idle read data is inverted so a stray sample never matches
  assign nv_rdata = nv_ack ? nv_mem[nv_addr] : ~nv_mem[nv_addr];
  always @(posedge clk) begin
    nv_ack <= nv_req & ~nv_ack;
    if (nv_req && nv_ack && nv_we) nv_mem[nv_addr] <= nv_wdata;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [71:0] mk(input logic [7:0] a, op, ty, bk, input logic [31:0] v);
    logic [63:0] b;
    logic [7:0] s;
    b = {a, op, ty, bk, v};
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = 8'(s + b[8*i +: 8]);
    return {b, s};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [71:0] frm, input logic [7:0] st, input logic [31:0] rv);
    logic [71:0] rsp;
    bit ok;
    host_u.send(frm, ok);
    if (ok) host_u.recv(rsp, ok);
    if (!ok) begin
      fails++;
      print_verdict();
    end else begin
      dev = dev_next;
      check(rsp, mk(HOST_ADDR, dev, st, frm[63:56], rv));
    end
  endtask
  task automatic cmd(input logic [7:0] op, ty, bk, input logic [31:0] v, st, rv);
    xfer(mk(dev, op, ty, bk, v), st[7:0], rv);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power_up();
    int n;
    n = 0;
    while (nv_req && n < 3000) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (nv_req) begin
      fails++;
      print_verdict();
    end
    cmd(OP_GET_GP, 8'h2A, BANK_USER, 32'h0, ST_OK, 32'h122A);
    check({40'h0, accum}, 72'h122A);
    cmd(OP_GET_GP, PAR_SERIAL_ADDR, BANK_GLOBAL, 32'h0, ST_OK, 32'h1);
    cmd(OP_GET_GP, 8'h2A, 8'h01, 32'h0, ST_BAD_VALUE, 32'h0);
    check({40'h0, accum}, 72'h1);
    $display("power-up test done");
  endtask
  task automatic t_store_restore();
    host_u.slow = 1'b1;
    cmd(OP_SET_GP, 8'h2A, BANK_USER, 32'hCAFE0001, ST_OK, 32'h0);
    cmd(OP_STORE_GP, 8'h2A, BANK_USER, 32'hFFFFFFFF, ST_OK, 32'h0);
    check({40'h0, nv_mem[10'h22A]}, 72'hCAFE0001);
    cmd(OP_SET_GP, 8'h2A, BANK_USER, 32'h12345678, ST_OK, 32'h0);
    check({40'h0, nv_mem[10'h22A]}, 72'hCAFE0001);
    cmd(OP_GET_GP, 8'h2A, BANK_USER, 32'h0, ST_OK, 32'h12345678);
    cmd(OP_RESTORE_GP, 8'h2A, BANK_USER, 32'h0, ST_OK, 32'h0);
    cmd(OP_GET_GP, 8'h2A, BANK_USER, 32'h0, ST_OK, 32'hCAFE0001);
    cmd(OP_SET_GP, 8'h05, BANK_IRQ, 32'h00000077, ST_OK, 32'h0);
    cmd(OP_GET_GP, 8'h05, BANK_IRQ, 32'h0, ST_OK, 32'h00000077);
    check({40'h0, nv_mem[10'h305]}, 72'h1305);
    host_u.slow = 1'b0;
    $display("store and restore test done");
  endtask
  task automatic t_output();
    cmd(OP_SET_OUT, OUT_PORT, BANK_USER, 32'h1, ST_OK, 32'h0);
    check({71'h0, gp_out}, 72'h1);
    cmd(OP_SET_OUT, 8'h01, BANK_USER, 32'h0, ST_BAD_VALUE, 32'h0);
    check({71'h0, gp_out}, 72'h1);
    cmd(OP_SET_OUT, OUT_PORT, BANK_USER, 32'h2, ST_BAD_VALUE, 32'h0);
    cmd(OP_SET_OUT, OUT_PORT, BANK_USER, 32'h0, ST_OK, 32'h0);
    check({71'h0, gp_out}, 72'h0);
    $display("output test done");
  endtask
  task automatic t_address();
    bit ok;
    int seen;
    dev_next = 8'h03;
    cmd(OP_SET_GP, PAR_SERIAL_ADDR, BANK_GLOBAL, 32'h3, ST_OK, 32'h0);
    check({40'h0, nv_mem[10'h042]}, 72'h3);
    check({64'h0, serial_addr}, 72'h3);
    host_u.send(mk(8'h01, OP_GET_GP, PAR_SERIAL_ADDR, BANK_GLOBAL, 32'h0), ok);
    if (!ok) begin
      fails++;
      print_verdict();
    end
    seen = 0;
    repeat (40) begin
      @(posedge clk);
      if (tx_valid === 1'b1) seen++;
    end
    #1;
    check({8'h0, 32'h0, 32'(seen)}, 72'h0);
    cmd(OP_GET_GP, PAR_SERIAL_ADDR, BANK_GLOBAL, 32'h0, ST_OK, 32'h3);
    dev_next = 8'h01;
    cmd(OP_SET_GP, PAR_SERIAL_ADDR, BANK_GLOBAL, 32'h1, ST_OK, 32'h0);
    $display("address test done");
  endtask
  task automatic t_bad_frame();
    logic [71:0] f;
    f = mk(dev, OP_GET_GP, 8'h2A, BANK_USER, 32'h0);
    f[0] = ~f[0];
    xfer(f, ST_BAD_CKSUM, 32'h0);
    cmd(8'h05, 8'h00, BANK_GLOBAL, 32'h0, ST_BAD_CMD, 32'h0);
    $display("bad frame test done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    t_power_up();
    t_store_restore();
    t_output();
    t_address();
    t_bad_frame();
    print_verdict();
  end
endmodule
